// [rtl/cdgm_pkg.sv]
// package: register map, field positions, reset values and state types of the clock divider and selector
package cdgm_pkg;
  localparam logic [3:0]  CDGM_CTRL_OFS      = 4'h0;
  localparam logic [3:0]  CDGM_STAT_OFS      = 4'h4;
  localparam int          CDGM_CTRL_RST_BIT  = 0;
  localparam int          CDGM_CTRL_REL_BIT  = 1;
  localparam int          CDGM_CTRL_RAT_LSB  = 2;
  localparam int          CDGM_CTRL_INS_BIT  = 4;
  localparam int          CDGM_CTRL_SEL_LSB  = 5;
  localparam logic [31:0] CDGM_CTRL_RST_VAL  = 32'h0000_0001;
  localparam int          CDGM_STAT_DIV_BIT  = 0;
  localparam int          CDGM_STAT_CUR_LSB  = 1;
  localparam int          CDGM_STAT_BSY_LSB  = 3;
  localparam int          CDGM_STAT_LIN_LSB  = 8;
  localparam int          CDGM_NUM_SEL       = 2;
  localparam int          CDGM_NUM_LINES     = 8;

  typedef enum logic [1:0] {
    CDGM_DIV2 = 2'b00,
    CDGM_DIV4 = 2'b01,
    CDGM_DIV8 = 2'b10
  } cdgm_ratio_t;

  typedef enum logic [0:0] {
    CDGM_SEL_RUN  = 1'b0,
    CDGM_SEL_PARK = 1'b1
  } cdgm_sel_st_t;

  typedef struct packed {
    logic                            ack;
    logic [31:0]                     rdat;
    logic                            div_rst;
    logic                            rel;
    logic [1:0]                      ratio;
    logic                            in_sel;
    logic [CDGM_NUM_SEL-1:0]         sel_req;
    logic                            prev_src;
    logic                            rst_sync;
    logic                            rel_sync;
    logic [2:0]                      cnt;
    logic [2:0]                      div_out;
    logic                            div_main;
    cdgm_sel_st_t [CDGM_NUM_SEL-1:0] st;
    logic [CDGM_NUM_SEL-1:0]         cur;
    logic [CDGM_NUM_SEL-1:0]         sel_out;
    logic [CDGM_NUM_LINES-1:0]       lines;
  } cdgm_state_t;
endpackage : cdgm_pkg

// [rtl/cdgm_top.sv]
// clock divider (/2 /4 /8) and two glitchless clock selectors feeding one quadrant's primary lines
//
// Decided for this implementation: the Wishbone register port and the placing of the registers.
`timescale 1ns/1ps
module cdgm_top #(
  parameter int WB_AW = 4
) (
  input  wire logic         CORE_CLK,
  input  wire logic         NRST,
  input  wire logic         PLL_PRIMARY_OUT,
  input  wire logic         EDGE_CLOCK,
  input  wire logic         WB_CYC_I,
  input  wire logic         WB_STB_I,
  input  wire logic         WB_WE_I,
  input  wire logic [WB_AW-1:0] WB_ADR_I,
  input  wire logic [3:0]   WB_SEL_I,
  input  wire logic [31:0]  WB_DAT_I,
  output logic [31:0]       WB_DAT_O,
  output logic              WB_ACK_O,
  output logic [2:0]        DIV_OUT,
  output logic              DIV_MAIN,
  output logic [7:0]        PRIMARY_LINES
);
  if (WB_AW < 3) begin : g_bad_aw
    $error("WB_AW must be at least 3");
  end

  cdgm_pkg::cdgm_state_t s_q;
  cdgm_pkg::cdgm_state_t s_d;

  logic       src;
  logic       src_rise;
  logic       req;
  logic [3:0] adr;
  logic [1:0] sa;
  logic [1:0] sb;

  // input clocks are sampled levels, so each must stay below half the core rate
  // selector 0 chooses pll/edge, selector 1 chooses divider/pll
  assign sa       = {s_q.div_main, PLL_PRIMARY_OUT};
  assign sb       = {PLL_PRIMARY_OUT, EDGE_CLOCK};
  assign src      = s_q.in_sel ? EDGE_CLOCK : PLL_PRIMARY_OUT;
  assign src_rise = src & ~s_q.prev_src;
  assign req      = WB_CYC_I & WB_STB_I;
  assign adr      = 4'(WB_ADR_I);

  function automatic logic sel_src(input logic cur, input logic a, input logic b);
    sel_src = cur ? b : a;
  endfunction : sel_src

  always_comb begin
    s_d          = s_q;
    s_d.prev_src = src;
    // wishbone: one registered answer, a cycle after the request; writes land on the ack edge
    s_d.ack      = req & ~s_q.ack;
    if (req & ~s_q.ack) begin
      s_d.rdat = 32'h0000_0000;
      if (!WB_WE_I && adr == cdgm_pkg::CDGM_CTRL_OFS) begin
        s_d.rdat[cdgm_pkg::CDGM_CTRL_RST_BIT] = s_q.div_rst;
        s_d.rdat[cdgm_pkg::CDGM_CTRL_REL_BIT] = s_q.rel;
        s_d.rdat[cdgm_pkg::CDGM_CTRL_RAT_LSB +: 2] = s_q.ratio;
        s_d.rdat[cdgm_pkg::CDGM_CTRL_INS_BIT] = s_q.in_sel;
        s_d.rdat[cdgm_pkg::CDGM_CTRL_SEL_LSB +: 2] = s_q.sel_req;
      end else if (!WB_WE_I && adr == cdgm_pkg::CDGM_STAT_OFS) begin
        s_d.rdat[cdgm_pkg::CDGM_STAT_DIV_BIT] = s_q.div_main;
        s_d.rdat[cdgm_pkg::CDGM_STAT_CUR_LSB +: 2] = s_q.cur;
        s_d.rdat[cdgm_pkg::CDGM_STAT_BSY_LSB +: 2] = {s_q.st[1] == cdgm_pkg::CDGM_SEL_PARK,
                                                     s_q.st[0] == cdgm_pkg::CDGM_SEL_PARK};
        s_d.rdat[cdgm_pkg::CDGM_STAT_LIN_LSB +: 8] = s_q.lines;
      end
    end
    if (req && s_q.ack && WB_WE_I && WB_SEL_I[0] && adr == cdgm_pkg::CDGM_CTRL_OFS) begin
      s_d.div_rst = WB_DAT_I[cdgm_pkg::CDGM_CTRL_RST_BIT];
      s_d.rel     = WB_DAT_I[cdgm_pkg::CDGM_CTRL_REL_BIT];
      s_d.ratio   = WB_DAT_I[cdgm_pkg::CDGM_CTRL_RAT_LSB +: 2];
      s_d.in_sel  = WB_DAT_I[cdgm_pkg::CDGM_CTRL_INS_BIT];
      s_d.sel_req = WB_DAT_I[cdgm_pkg::CDGM_CTRL_SEL_LSB +: 2];
    end
    // controls reach the counter only on an input clock edge, so the phase
    // is pinned to the first input edge after release
    if (src_rise) begin
      s_d.rst_sync = s_q.div_rst;
      s_d.rel_sync = s_q.rel;
      s_d.cnt      = s_q.div_rst ? 3'h0 : 3'(s_q.cnt + 3'h1);
    end
    if (s_d.rst_sync) begin
      s_d.cnt = 3'h0;
    end
    s_d.div_out = (s_d.rst_sync | ~s_d.rel_sync) ? 3'h0 : s_d.cnt;
    case (s_q.ratio)
      cdgm_pkg::CDGM_DIV4: s_d.div_main = s_d.div_out[1];
      cdgm_pkg::CDGM_DIV8: s_d.div_main = s_d.div_out[2];
      default:             s_d.div_main = s_d.div_out[0];
    endcase
    // selector: park low once the old clock is low, then wait for the new one low
    for (int i = 0; i < cdgm_pkg::CDGM_NUM_SEL; i++) begin
      case (s_q.st[i])
        cdgm_pkg::CDGM_SEL_RUN: begin
          s_d.sel_out[i] = sel_src(s_q.cur[i], sa[i], sb[i]);
          if (s_q.sel_req[i] != s_q.cur[i] && !sel_src(s_q.cur[i], sa[i], sb[i])) begin
            s_d.st[i] = cdgm_pkg::CDGM_SEL_PARK;
          end
        end
        cdgm_pkg::CDGM_SEL_PARK: begin
          s_d.sel_out[i] = 1'b0;
          if (!sel_src(~s_q.cur[i], sa[i], sb[i])) begin
            s_d.cur[i] = ~s_q.cur[i];
            s_d.st[i]  = cdgm_pkg::CDGM_SEL_RUN;
          end
        end
        default: begin
          s_d.sel_out[i] = 1'b0;
          s_d.st[i]      = cdgm_pkg::CDGM_SEL_RUN;
        end
      endcase
    end
    s_d.lines = {s_d.sel_out, s_d.div_main, s_d.div_out, EDGE_CLOCK, PLL_PRIMARY_OUT};
  end

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      s_q         <= '0;
      s_q.div_rst <= cdgm_pkg::CDGM_CTRL_RST_VAL[cdgm_pkg::CDGM_CTRL_RST_BIT];
      s_q.rst_sync <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign WB_DAT_O      = s_q.rdat;
  assign WB_ACK_O      = s_q.ack;
  assign DIV_OUT       = s_q.div_out;
  assign DIV_MAIN      = s_q.div_main;
  assign PRIMARY_LINES = s_q.lines;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  logic src_rise_q;
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      src_rise_q <= 1'b0;
    end else begin
      src_rise_q <= src_rise;
    end
  end

  sequence park_then_run0;
    s_q.st[0] == cdgm_pkg::CDGM_SEL_PARK ##1 s_q.st[0] == cdgm_pkg::CDGM_SEL_RUN;
  endsequence

  AST_DIV_RESET_LOW: assert property (s_q.rst_sync |-> s_q.div_out == 3'h0 && s_q.cnt == 3'h0)
    else $error("divided outputs not low during reset");
  AST_DIV2_TOGGLE: assert property (src_rise && !s_q.div_rst && s_q.rel && s_q.rel_sync && !s_q.rst_sync
      |=> s_q.div_out[0] != $past(s_q.div_out[0]))
    else $error("divide-by-two output missed an input edge");
  AST_DIV_HOLD: assert property (!src_rise |=> $stable(s_q.cnt))
    else $error("divider advanced without an input edge");
  AST_SYNC_EDGE: assert property (!src_rise |=> $stable(s_q.rst_sync) && $stable(s_q.rel_sync))
    else $error("reset or release changed away from an input edge");
  AST_RELEASE_GATE: assert property (!s_q.rel_sync |-> s_q.div_out == 3'h0)
    else $error("outputs toggled before release");
  AST_EDGE_SOURCE: assert property (s_q.in_sel && EDGE_CLOCK && !s_q.prev_src |=> src_rise_q)
    else $error("edge clock not used as divider input");
  AST_PARK_LOW: assert property (s_q.st[0] == cdgm_pkg::CDGM_SEL_PARK ##1 s_q.st[0] == cdgm_pkg::CDGM_SEL_PARK
      |-> PRIMARY_LINES[6] == 1'b0)
    else $error("selector output not held low while parked");
  AST_SWITCH_FLIP: assert property (park_then_run0 |-> s_q.cur[0] != $past(s_q.cur[0]))
    else $error("selector left park without changing source");
  AST_LINE_RISE: assert property ($rose(PRIMARY_LINES[6]) |-> $past(sel_src(s_q.cur[0], sa[0], sb[0])))
    else $error("line seven rose without its current source high");
  AST_WB_ACK: assert property (req && !WB_ACK_O |=> WB_ACK_O ##1 !WB_ACK_O)
    else $error("wishbone ack not a single cycle answer");

  // the line map is fixed, so a wiring slip between divider, selectors and
  // lines shows up at once rather than as a clock problem downstream
  sequence park_then_run1;
    s_q.st[1] == cdgm_pkg::CDGM_SEL_PARK ##1 s_q.st[1] == cdgm_pkg::CDGM_SEL_RUN;
  endsequence

  AST_LINES_DIV: assert property (PRIMARY_LINES[5:2] == {DIV_MAIN, DIV_OUT})
    else $error("divided outputs not on their primary lines");

  AST_LINES_INPUTS: assert property (1'b1
      |=> PRIMARY_LINES[1:0] == $past({EDGE_CLOCK, PLL_PRIMARY_OUT}))
    else $error("input clocks not on their primary lines");

  AST_PARK_LOW1: assert property (s_q.st[1] == cdgm_pkg::CDGM_SEL_PARK ##1 s_q.st[1] == cdgm_pkg::CDGM_SEL_PARK
      |-> PRIMARY_LINES[7] == 1'b0)
    else $error("second selector output not held low while parked");

  AST_SWITCH_FLIP1: assert property (park_then_run1 |-> s_q.cur[1] != $past(s_q.cur[1]))
    else $error("second selector left park without changing source");

  AST_LINE_RISE1: assert property ($rose(PRIMARY_LINES[7]) |-> $past(sel_src(s_q.cur[1], sa[1], sb[1])))
    else $error("line eight rose without its current source high");

  AST_DIV4_MAIN: assert property (s_q.ratio == cdgm_pkg::CDGM_DIV4 |=> DIV_MAIN == DIV_OUT[1])
    else $error("divide-by-four not routed to the main output");

  AST_DIV8_MAIN: assert property (s_q.ratio == cdgm_pkg::CDGM_DIV8 |=> DIV_MAIN == DIV_OUT[2])
    else $error("divide-by-eight not routed to the main output");

  AST_RESET_STAYS_LOW: assert property (s_q.div_rst && s_q.rst_sync |=> DIV_OUT == 3'h0)
    else $error("divided outputs left low reset while reset still requested");

  // the first input rise that leaves reset with release already set starts from a count of one,
  // which is what fixes the phase of every divided output
  AST_RELEASE_START: assert property (src_rise && !s_q.div_rst && s_q.rel && s_q.rst_sync
      |=> DIV_OUT == 3'h1)
    else $error("divider did not start from one after release");

  // a control write lands on the edge at which ack is seen
  AST_CTRL_WRITE: assert property (req && WB_ACK_O && WB_WE_I && WB_SEL_I[0] && adr == cdgm_pkg::CDGM_CTRL_OFS
      |=> s_q.rel == $past(WB_DAT_I[cdgm_pkg::CDGM_CTRL_REL_BIT]))
    else $error("release bit not taken from the control write");
endmodule : cdgm_top

// [tb/cdgm_clk_src.sv]
// far-side clock source: slow pll and edge clocks as levels in the core clock domain
`timescale 1ns/1ps
module cdgm_clk_src #(
  parameter int PLL_HALF  = 3,
  parameter int EDGE_HALF = 4
) (
  input  wire logic core_clk,
  output logic      pll_q,
  output logic      edge_q
);
  int pll_n  = 0;
  int edge_n = 0;
  initial pll_q = 1'b0;
  initial edge_q = 1'b0;
  // both run well below half the core rate, as the sampled inputs need
  always @(posedge core_clk) begin
    pll_n <= (pll_n == PLL_HALF - 1) ? 0 : pll_n + 1;
    edge_n <= (edge_n == EDGE_HALF - 1) ? 0 : edge_n + 1;
    if (pll_n == PLL_HALF - 1) pll_q <= ~pll_q;
    if (edge_n == EDGE_HALF - 1) edge_q <= ~edge_q;
  end
endmodule : cdgm_clk_src

// [tb/test_clock_divider_and_glitchless_mux.sv]
// self-checking bench: register access, divider ratios and selector switching
`timescale 1ns/1ps
module test_clock_divider_and_glitchless_mux;
  logic        core_clk = 1'b0;
  logic        nrst     = 1'b0;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, pll, edg, ack, div_main;
  logic [3:0]  adr      = 4'h0;
  logic [31:0] wdat     = 32'h0000_0000;
  logic [31:0] dat_o, ctrl_m = 32'h0000_0001;
  logic [2:0]  div_out, out_m = 3'h0, cnt_m = 3'h0;
  logic        main_m = 1'b0, prev_m = 1'b0, in_now, rst_m = 1'b1, rel_m = 1'b0;
  logic [1:0]  prim_m = 2'b00;
  logic [2:0]  gate_m;
  logic [7:0]  lines;
  logic [15:0] lfsr_q   = 16'h0041;
  int          fail_count = 0, compares = 0;
  always #2.5 core_clk = ~core_clk;
  cdgm_top #(.WB_AW(4)) cdgm_top_i (.CORE_CLK(core_clk), .NRST(nrst), .PLL_PRIMARY_OUT(pll),
    .EDGE_CLOCK(edg), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hf),
    .WB_DAT_I(wdat), .WB_DAT_O(dat_o), .WB_ACK_O(ack), .DIV_OUT(div_out), .DIV_MAIN(div_main),
    .PRIMARY_LINES(lines));
  cdgm_clk_src cdgm_clk_src_i (.core_clk(core_clk), .pll_q(pll), .edge_q(edg));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic end_of_test;
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  // one classic cycle; the request holds until ack is sampled, then one idle cycle
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
    @(posedge core_clk);
    while (ack !== 1'b1 && n < 20) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 20) begin fail_count++; end_of_test(); end
    check("ack latency", n, 1);
    q = dat_o;
    if (w && a == cdgm_pkg::CDGM_CTRL_OFS) ctrl_m <= d & 32'h0000_007f;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
    @(posedge core_clk);
  endtask : wb
  function automatic logic [31:0] mk(input logic [1:0] s, input logic i, input logic [1:0] r,
                                     input logic rl, input logic rs);
    return 32'({s, i, r, rl, rs});
  endfunction : mk
  // reference divider: reset and release are taken on a sampled rise of the chosen input,
  // the count steps on that rise and the outputs show the new count after the same edge
  always @(posedge core_clk) begin
    in_now = ctrl_m[cdgm_pkg::CDGM_CTRL_INS_BIT] ? edg : pll;
    if (!nrst) begin
      cnt_m = 3'h0;
      rst_m = 1'b1;
      rel_m = 1'b0;
      prev_m = 1'b0;
    end else begin
      if (in_now && !prev_m) begin
        rst_m = ctrl_m[0];
        rel_m = ctrl_m[1];
        cnt_m = ctrl_m[0] ? 3'h0 : 3'(cnt_m + 3'h1);
      end
      prev_m = in_now;
    end
    gate_m = (rst_m || !rel_m) ? 3'h0 : cnt_m;
    out_m <= gate_m;
    main_m <= (ctrl_m[3:2] == 2'b01) ? gate_m[1] : (ctrl_m[3:2] == 2'b10) ? gate_m[2] : gate_m[0];
    prim_m <= nrst ? {edg, pll} : 2'b00;
  end
  always @(negedge core_clk) begin
    check("div_out", 32'(div_out), 32'(out_m));
    check("div_main", 32'(div_main), 32'(main_m));
    check("lines", 32'(lines[5:0]), 32'({main_m, out_m, prim_m}));
  end
  initial begin
    logic [31:0] q;
    logic [1:0]  s;
    repeat (4) @(posedge core_clk);
    nrst <= 1'b1;
    @(posedge core_clk);
    wb(1'b0, cdgm_pkg::CDGM_CTRL_OFS, 32'h0000_0000, q);
    check("ctrl reset", q, cdgm_pkg::CDGM_CTRL_RST_VAL);
    wb(1'b1, 4'h8, 32'hffff_ffff, q);
    wb(1'b0, 4'h8, 32'h0000_0000, q);
    check("unmapped", q, 32'h0000_0000);
    for (int t = 0; t < 8; t++) begin
      lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      wb(1'b1, cdgm_pkg::CDGM_CTRL_OFS, mk(2'b00, t[0], lfsr_q[1:0], 1'b0, 1'b1), q);
      repeat (lfsr_q[7:4]) @(posedge core_clk);
      wb(1'b1, cdgm_pkg::CDGM_CTRL_OFS, mk(2'b00, t[0], lfsr_q[1:0], 1'b1, 1'b0), q);
      repeat (60) @(posedge core_clk);
      wb(1'b0, cdgm_pkg::CDGM_CTRL_OFS, 32'h0000_0000, q);
      check("ctrl", q, mk(2'b00, t[0], lfsr_q[1:0], 1'b1, 1'b0));
      $display("divider test %0d done", t);
    end
    for (int t = 0; t < 4; t++) begin
      s = (t == 3) ? 2'b00 : t[1:0] + 2'b01;
      lfsr_q = {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
      repeat (lfsr_q[2:0]) @(posedge core_clk);
      wb(1'b1, cdgm_pkg::CDGM_CTRL_OFS, mk(s, 1'b0, 2'b00, 1'b1, 1'b0), q);
      repeat (40) @(posedge core_clk);
      wb(1'b0, cdgm_pkg::CDGM_STAT_OFS, 32'h0000_0000, q);
      check("selector state", 32'(q[4:1]), 32'(s));
      $display("selector test %0d done", t);
    end
    end_of_test();
  end
endmodule : test_clock_divider_and_glitchless_mux
